// >>> aslbu_pkg.sv
// Purpose: shared constants for the serial unit and its controller
// Assumes: one clock, core_clk at 20 MHz
// Notes: unit register indices sit on a 3-bit internal bus, 8-bit data
package aslbu_pkg;
    // unit registers on the link bus
    localparam logic [2:0] A_MODE = 3'h0; // operation_mode_reg
    localparam logic [2:0] A_CKSEL = 3'h1; // clock_select_reg
    localparam logic [2:0] A_BAUD = 3'h2; // baud_divisor_reg
    localparam logic [2:0] A_LCTL = 3'h3; // line_control_reg
    localparam logic [2:0] A_TXB = 3'h4; // tx_buffer_reg
    localparam logic [2:0] A_TXST = 3'h5; // tx_status_reg
    localparam logic [2:0] A_ERRST = 3'h6; // rx_error_status_reg
    // bit positions
    localparam int MODE_PWR = 7; // unit_power_bit
    localparam int MODE_TXE = 6; // tx_enable_bit
    localparam int MODE_RXE = 5; // rx_enable_bit
    localparam int LCTL_BRF = 7; // break_rx_flag
    localparam int LCTL_BRT = 6; // break_rx_trigger
    localparam int LCTL_BTT = 5; // break_tx_trigger
    localparam int TXST_BF = 1; // tx_buffer_full_flag
    localparam int TXST_SF = 0; // tx_shift_busy_flag
    localparam int ERR_BRK = 0; // sync break too short
    // reset values and codes
    localparam logic [7:0] BAUD_RST = 8'h10;
    localparam logic [3:0] PS_RST = 4'h0;
    localparam logic [3:0] PS_OSC = 4'hf; // prescale code naming the internal oscillator
    // break timing in bit times
    localparam logic [3:0] BRK_TX_BITS = 4'hd; // 13 low bits
    localparam logic [3:0] BRK_RX_MIN = 4'hb; // 11 low bits or more
    localparam logic [3:0] FRAME_BITS = 4'ha; // start, 8 data, stop
    localparam logic [15:0] BRK_TX_PAT = 16'he000; // 13 zeros then stop
    // controller apb offsets
    localparam logic [7:0] R_CMD = 8'h00;
    localparam logic [7:0] R_STAT = 8'h04;
    localparam logic [7:0] R_IRQ_ST = 8'h08;
    localparam logic [7:0] R_IRQ_CLR = 8'h0c;
    localparam logic [7:0] R_IRQ_EN = 8'h10;
    // controller commands
    localparam logic [3:0] C_START = 4'h1;
    localparam logic [3:0] C_STOP = 4'h2;
    localparam logic [3:0] C_SETPS = 4'h3;
    localparam logic [3:0] C_SETBAUD = 4'h4;
    localparam logic [3:0] C_SEND = 4'h5;
    localparam logic [3:0] C_BRKTX = 4'h6;
    localparam logic [3:0] C_BRKRX = 4'h7;
    localparam logic [3:0] C_RDERR = 4'h8;
    localparam logic [3:0] C_TXINIT = 4'h9;
    // interrupt status bits
    localparam int I_DONE = 0;
    localparam int I_REF = 1;
    localparam int I_TXC = 2;
    localparam int I_BRK = 3;
    localparam int I_BERR = 4;
    localparam int I_N = 5;
    // sequencer step kinds
    localparam logic [1:0] K_NONE = 2'h0;
    localparam logic [1:0] K_WR = 2'h1;
    localparam logic [1:0] K_RD = 2'h2;
    localparam logic [1:0] K_POLL = 2'h3;
endpackage

// >>> aslbu_link_if.sv
// Purpose: register bus and event lines between unit and controller
// Assumes: both ends on core_clk
// Notes: req is held until ack, ack is a one-cycle pulse
`timescale 1ns/1ps
interface aslbu_link_if (
    input wire logic core_clk,
    input wire logic sys_rst
);
    logic req; // access request, level
    logic we; // write when high
    logic [2:0] addr; // register index
    logic [7:0] wdata; // write data
    logic [7:0] rdata; // read data, valid with ack
    logic ack; // access done, pulse
    logic tx_done; // frame or break sent, pulse
    logic brk_done; // break received, pulse
    logic brk_err; // break too short, pulse
    modport dev (input core_clk, sys_rst, req, we, addr, wdata,
                 output rdata, ack, tx_done, brk_done, brk_err);
    modport ctl (input core_clk, sys_rst, rdata, ack, tx_done, brk_done, brk_err,
                 output req, we, addr, wdata);
endinterface

// >>> aslbu_serial_dev.sv
// Purpose: async serial unit with break send and break receive
// Assumes: the controller keeps the programming order it owes
// Notes: base clock is core_clk divided by a power of two
`timescale 1ns/1ps
module aslbu_serial_dev (
    aslbu_link_if.dev link,
    input wire logic rxd_pin,
    output logic txd_pin
);
    typedef struct packed {
        logic [7:0] mode; // power and enables
        logic [3:0] ps; // prescale exponent
        logic [7:0] div; // baud divisor
        logic brt; // break receive armed
        logic btt; // break send pending
        logic brf; // break seen
        logic err; // break error
        logic [7:0] txb; // transmit buffer
        logic bf; // buffer full
        logic sf; // shifter busy
        logic [15:0] sh; // shifter
        logic [3:0] nbit; // bits left
        logic [15:0] pcnt; // prescale counter
        logic [7:0] bcnt; // divisor counter
        logic half; // halving flop
        logic [3:0] low; // low bit times seen
        logic [2:0] rs; // pin synchroniser
        logic rxl; // filtered line level
        logic wt; // wait state taken
        logic ack;
        logic [7:0] rdata;
        logic txd;
        logic txdn;
        logic bdn;
        logic ber;
    } aslbu_dev_t;

    aslbu_dev_t r, n;
    logic base; // base clock tick
    logic tick; // bit tick
    logic [15:0] mask;

    // next state of the whole unit
    always_comb begin
        n = r;
        n.ack = 1'b0;
        n.txdn = 1'b0;
        n.bdn = 1'b0;
        n.ber = 1'b0;
        tick = 1'b0;
        // count clock is the running clock divided by 2 to the power ps; ps of 0 passes it through undivided
        mask = ~(16'hffff << r.ps); // R5
        base = (r.pcnt & mask) == mask;
        n.pcnt = r.pcnt + 16'h1;
        // 8-bit counter, its output halved to give the bit rate
        if (base) begin
            if (r.bcnt + 8'h1 >= r.div) begin // R9
                n.bcnt = 8'h0;
                n.half = ~r.half; // R9
                tick = r.half;
            end else begin
                n.bcnt = r.bcnt + 8'h1;
            end
        end
        // pin synchroniser: level moves when stages two and three agree
        n.rs = {r.rs[1:0], rxd_pin};
        if (r.rs[2] == r.rs[1]) begin
            n.rxl = r.rs[2];
        end
        // register access; error status read takes one extra cycle
        if (link.req && !r.ack) begin
            if (!link.we && link.addr == aslbu_pkg::A_ERRST && !r.wt) begin
                n.wt = 1'b1; // R1
            end else begin
                n.wt = 1'b0;
                n.ack = 1'b1;
                n.rdata = 8'h0;
                case (link.addr)
                    aslbu_pkg::A_MODE: n.rdata = r.mode;
                    aslbu_pkg::A_CKSEL: n.rdata = {4'h0, r.ps};
                    aslbu_pkg::A_BAUD: n.rdata = r.div;
                    aslbu_pkg::A_LCTL: n.rdata = {r.brf, 7'h0}; // R14 R16
                    aslbu_pkg::A_TXST: n.rdata = {6'h0, r.bf, r.sf};
                    aslbu_pkg::A_ERRST: begin
                        n.rdata = {7'h0, r.err}; // R1
                        if (!link.we) begin
                            n.err = 1'b0; // read clears the error
                        end
                    end
                    default: n.rdata = 8'h0;
                endcase
                if (link.we) begin
                    case (link.addr)
                        aslbu_pkg::A_MODE: n.mode = {link.wdata[7:5], 5'h0};
                        aslbu_pkg::A_CKSEL: n.ps = link.wdata[3:0];
                        aslbu_pkg::A_BAUD: n.div = link.wdata;
                        aslbu_pkg::A_LCTL: begin
                            // a same-value refresh is taken at any time; a 1 re-arms
                            if (link.wdata[aslbu_pkg::LCTL_BRT]) begin // R10 R11
                                n.brt = 1'b1;
                                n.brf = 1'b0;
                                n.low = 4'h0;
                            end
                            if (link.wdata[aslbu_pkg::LCTL_BTT]) begin // R10
                                n.btt = 1'b1;
                            end
                        end
                        aslbu_pkg::A_TXB: begin
                            n.txb = link.wdata;
                            n.bf = 1'b1;
                        end
                        default: n.wt = 1'b0;
                    endcase
                end
            end
        end
        // transmitter, stepped once per bit time
        if (tick) begin
            if (r.sf) begin
                if (r.nbit == 4'h1) begin
                    n.sf = 1'b0;
                    n.txd = 1'b1;
                    n.txdn = 1'b1;
                    n.btt = 1'b0; // R16
                end else begin
                    n.sh = {1'b1, r.sh[15:1]};
                    n.txd = r.sh[1];
                    n.nbit = r.nbit - 4'h1;
                end
            end else if (r.btt && r.mode[aslbu_pkg::MODE_TXE]) begin
                n.sf = 1'b1;
                n.sh = aslbu_pkg::BRK_TX_PAT;
                n.txd = 1'b0;
                n.nbit = aslbu_pkg::BRK_TX_BITS + 4'h1;
            end else if (r.bf && r.mode[aslbu_pkg::MODE_TXE]) begin
                n.sf = 1'b1;
                n.bf = 1'b0; // buffer moves into the shifter
                n.sh = {6'h3f, 1'b1, r.txb, 1'b0};
                n.txd = 1'b0;
                n.nbit = aslbu_pkg::FRAME_BITS;
            end
            // break receiver, one sample per bit time
            if (r.brt && r.mode[aslbu_pkg::MODE_RXE]) begin
                if (!r.rxl) begin
                    n.low = (r.low == 4'hf) ? r.low : r.low + 4'h1;
                end else if (r.low != 4'h0) begin
                    n.low = 4'h0;
                    n.brt = 1'b0; // R11 R14
                    n.brf = 1'b1; // R12
                    if (r.low >= aslbu_pkg::BRK_RX_MIN) begin
                        n.bdn = 1'b1; // R11
                    end else begin
                        n.err = 1'b1; // R12
                        n.ber = 1'b1;
                    end
                end
            end
        end
        // power off parks flags, triggers, shifter and divisor counter; settings, buffer and prescale counter are kept
        if (!n.mode[aslbu_pkg::MODE_PWR]) begin // R18
            n.brt = 1'b0;
            n.btt = 1'b0;
            n.brf = 1'b0;
            n.err = 1'b0;
            n.bf = 1'b0;
            n.sf = 1'b0;
            n.txd = 1'b1;
            n.bcnt = 8'h0;
            n.half = 1'b0;
            n.low = 4'h0;
        end
    end

    // one register for all state
    always_ff @(posedge link.core_clk or posedge link.sys_rst) begin
        if (link.sys_rst) begin
            r <= '0;
            r.div <= aslbu_pkg::BAUD_RST;
            r.ps <= aslbu_pkg::PS_RST;
            r.txd <= 1'b1;
            r.rs <= 3'h7;
            r.rxl <= 1'b1;
        end else begin
            r <= n;
        end
    end

    assign link.ack = r.ack;
    assign link.rdata = r.rdata;
    assign link.tx_done = r.txdn;
    assign link.brk_done = r.bdn;
    assign link.brk_err = r.ber;
    assign txd_pin = r.txd;
endmodule

// >>> aslbu_ctl.sv
// Purpose: apb controller that programs the serial unit in safe order
// Assumes: apb master on core_clk, unit joined through aslbu_link_if
// Notes: one command at a time; a command while busy is refused
`timescale 1ns/1ps
// Notes on behaviour
// [R1] error status read answers one cycle late
// [R2] no error read with fast clock stopped
// [R3] next byte only when buffer-full reads 0
// [R4] transmit init only after shift-busy reads 0
// [R5] count clock divides the running clock
// [R6] internal oscillator never chosen as base
// [R7] prescaler changed only with power off
// [R8] divisor changed only with enables off
// [R9] bit rate is divisor counter halved
// [R10] line control refresh accepted while running
// [R11] refresh with trigger set restarts reception
// [R12] break error holds flag; re-arm reception
// [R13] break receive armed only with power, receive
// [R14] receive trigger reads 0, self-clears
// [R15] break send only with power, transmit
// [R16] send trigger reads 0, clears at end
// [R17] power on first, off last
// [R18] power off holds unit in reset; here settings, buffer and prescale counter are kept
module aslbu_ctl (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    input wire logic hs_clk_stopped,
    aslbu_link_if.ctl link
);
    typedef enum logic [1:0] {S_IDLE, S_ISSUE, S_WAIT} aslbu_st_t;

    typedef struct packed {
        aslbu_st_t st;
        logic req;
        logic we;
        logic [2:0] addr;
        logic [7:0] wdata;
        logic [1:0][1:0] okind; // up to two steps per command
        logic [1:0][2:0] oaddr;
        logic [1:0][7:0] odata; // write data, or poll mask
        logic step;
        logic [7:0] mode; // copy of what was written to the unit
        logic [7:0] rdval; // last value read
        logic [3:0] lcode;
        logic [7:0] larg;
        logic [4:0] ist; // sticky events
        logic [4:0] ien;
        logic rearm; // re-arm owed after a break error
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic irq;
    } aslbu_ctl_t;

    aslbu_ctl_t r, n;
    logic go; // start a command this cycle
    logic [3:0] code;
    logic [7:0] arg;
    logic [4:0] ev;
    logic [4:0] clr;
    logic mapped;
    logic pw, te, re;

    // next state of the controller
    always_comb begin
        n = r;
        go = 1'b0;
        code = 4'h0;
        arg = 8'h0;
        ev = 5'h0;
        clr = 5'h0;
        n.pready = 1'b0;
        n.pslverr = 1'b0;
        pw = r.mode[aslbu_pkg::MODE_PWR];
        te = r.mode[aslbu_pkg::MODE_TXE];
        re = r.mode[aslbu_pkg::MODE_RXE];
        mapped = paddr == aslbu_pkg::R_CMD || paddr == aslbu_pkg::R_STAT
            || paddr == aslbu_pkg::R_IRQ_ST || paddr == aslbu_pkg::R_IRQ_CLR
            || paddr == aslbu_pkg::R_IRQ_EN;
        // apb: answer in the cycle after the access phase opens
        if (psel && penable && !r.pready) begin
            n.pready = 1'b1;
            n.pslverr = !mapped;
            case (paddr)
                aslbu_pkg::R_CMD: n.prdata = {16'h0, r.larg, 4'h0, r.lcode};
                aslbu_pkg::R_STAT: n.prdata = {8'h0, r.rdval, r.mode, 7'h0, r.st != S_IDLE};
                aslbu_pkg::R_IRQ_ST: n.prdata = {27'h0, r.ist};
                aslbu_pkg::R_IRQ_EN: n.prdata = {27'h0, r.ien};
                default: n.prdata = 32'h0;
            endcase
        end
        // writes land on the edge that samples pready high
        if (psel && penable && r.pready && pwrite && !r.pslverr) begin
            case (paddr)
                aslbu_pkg::R_CMD: begin
                    if (r.st != S_IDLE) begin
                        ev[aslbu_pkg::I_REF] = 1'b1;
                    end else begin
                        go = 1'b1;
                        code = pwdata[3:0];
                        arg = pwdata[15:8];
                    end
                end
                aslbu_pkg::R_IRQ_CLR: clr = pwdata[4:0];
                aslbu_pkg::R_IRQ_EN: n.ien = pwdata[4:0];
                default: clr = 5'h0;
            endcase
        end
        // owed re-arm waits for an idle cycle with no command
        if (!go && r.rearm && r.st == S_IDLE) begin
            go = 1'b1;
            code = aslbu_pkg::C_BRKRX;
            n.rearm = 1'b0; // R12
        end
        // a command becomes up to two steps, a poll step repeating its read
        if (go) begin
            n.lcode = code;
            n.larg = arg;
            n.okind = {aslbu_pkg::K_NONE, aslbu_pkg::K_WR};
            n.oaddr = {3'h0, 3'h0};
            n.odata = {8'h0, 8'h0};
            n.step = 1'b0;
            n.st = S_ISSUE;
            case (code)
                aslbu_pkg::C_START: begin
                    // power first, enables in a second write
                    n.okind[1] = aslbu_pkg::K_WR; // R17
                    n.oaddr = {aslbu_pkg::A_MODE, aslbu_pkg::A_MODE};
                    n.odata[0] = 8'h80; // R17
                    n.odata[1] = 8'h80 | (arg & 8'h60);
                end
                aslbu_pkg::C_STOP: begin
                    // enables off, then power off
                    n.okind[1] = aslbu_pkg::K_WR; // R17
                    n.oaddr = {aslbu_pkg::A_MODE, aslbu_pkg::A_MODE};
                    n.odata[0] = r.mode & 8'h80;
                    n.odata[1] = 8'h0;
                end
                aslbu_pkg::C_SETPS: begin
                    // the oscillator code is refused; serial timing is not assured on it
                    if (pw || arg[3:0] == aslbu_pkg::PS_OSC) begin // R6 R7
                        n.st = S_IDLE;
                    end
                    n.oaddr[0] = aslbu_pkg::A_CKSEL;
                    n.odata[0] = {4'h0, arg[3:0]};
                end
                aslbu_pkg::C_SETBAUD: begin
                    if (te || re) begin // R8
                        n.st = S_IDLE;
                    end
                    n.oaddr[0] = aslbu_pkg::A_BAUD;
                    n.odata[0] = arg;
                end
                aslbu_pkg::C_SEND: begin
                    // wait for an empty buffer, else the byte is lost
                    n.okind = {aslbu_pkg::K_WR, aslbu_pkg::K_POLL}; // R3
                    n.oaddr = {aslbu_pkg::A_TXB, aslbu_pkg::A_TXST};
                    n.odata = {arg, 8'h02}; // R3
                end
                aslbu_pkg::C_BRKTX: begin
                    if (!(pw && te)) begin // R15
                        n.st = S_IDLE;
                    end
                    n.oaddr[0] = aslbu_pkg::A_LCTL;
                    n.odata[0] = 8'h20;
                end
                aslbu_pkg::C_BRKRX: begin
                    if (!(pw && re)) begin // R13
                        n.st = S_IDLE;
                    end
                    n.oaddr[0] = aslbu_pkg::A_LCTL;
                    n.odata[0] = 8'h40; // R11
                end
                aslbu_pkg::C_RDERR: begin
                    if (hs_clk_stopped) begin // R2
                        n.st = S_IDLE;
                    end
                    n.okind[0] = aslbu_pkg::K_RD;
                    n.oaddr[0] = aslbu_pkg::A_ERRST;
                end
                aslbu_pkg::C_TXINIT: begin
                    // shifter must be idle before transmit is reset
                    n.okind = {aslbu_pkg::K_WR, aslbu_pkg::K_POLL}; // R4
                    n.oaddr = {aslbu_pkg::A_MODE, aslbu_pkg::A_TXST};
                    n.odata = {r.mode & 8'hbf, 8'h01}; // R4
                end
                default: n.st = S_IDLE;
            endcase
            if (n.st == S_IDLE) begin
                ev[aslbu_pkg::I_REF] = 1'b1;
            end
        end
        // sequencer
        case (r.st)
            S_ISSUE: begin
                n.req = 1'b1;
                n.we = r.okind[r.step] == aslbu_pkg::K_WR;
                n.addr = r.oaddr[r.step];
                n.wdata = r.odata[r.step];
                n.st = S_WAIT;
            end
            S_WAIT: begin
                if (link.ack) begin
                    n.req = 1'b0;
                    n.st = S_ISSUE;
                    if (!r.we) begin
                        n.rdval = link.rdata;
                    end
                    if (r.we && r.addr == aslbu_pkg::A_MODE) begin
                        n.mode = r.wdata;
                    end
                    // a poll repeats while its masked bit is still set
                    if (r.okind[r.step] == aslbu_pkg::K_POLL && (link.rdata & r.wdata) != 8'h0) begin // R3 R4
                        n.st = S_ISSUE;
                    end else if (!r.step && r.okind[1] != aslbu_pkg::K_NONE) begin
                        n.step = 1'b1;
                    end else begin
                        n.st = S_IDLE;
                        ev[aslbu_pkg::I_DONE] = 1'b1;
                    end
                end
            end
            default: n.req = 1'b0;
        endcase
        // poll reads carry the mask from the data table on wdata
        if (r.st == S_ISSUE && r.okind[r.step] == aslbu_pkg::K_POLL) begin
            n.wdata = r.odata[r.step];
        end
        // unit events
        ev[aslbu_pkg::I_TXC] = link.tx_done;
        ev[aslbu_pkg::I_BRK] = link.brk_done;
        ev[aslbu_pkg::I_BERR] = link.brk_err;
        if (link.brk_err) begin
            n.rearm = 1'b1; // R12
        end
        // a new event wins over a clear in the same cycle
        n.ist = (r.ist & ~clr) | ev;
        n.irq = |(n.ist & n.ien);
    end

    // one register for all state
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            r <= '0;
            r.st <= S_IDLE;
        end else begin
            r <= n;
        end
    end

    assign prdata = r.prdata;
    assign pready = r.pready;
    assign pslverr = r.pslverr;
    assign irq = r.irq;
    assign link.req = r.req;
    assign link.we = r.we;
    assign link.addr = r.addr;
    assign link.wdata = r.wdata;
endmodule

// >>> aslbu_link_props.sv
// Purpose: checks on the link between controller and serial unit
// Assumes: one clock, asynchronous active-high reset
// Notes: mode_copy mirrors taken mode writes
`timescale 1ns/1ps
module aslbu_link_props (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic req,
    input wire logic we,
    input wire logic [2:0] addr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic ack,
    input wire logic tx_done,
    input wire logic brk_done,
    input wire logic brk_err
);
    logic [7:0] mode_copy; // power and enables as the unit holds them
    logic wr_take; // write the unit takes at this edge
    assign wr_take = req && we && !ack;
    // mirror of mode writes
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            mode_copy <= 8'h00;
        end else if (wr_take && addr == aslbu_pkg::A_MODE) begin
            mode_copy <= wdata;
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    AST_ERR_WAIT: assert property ($rose(req) && !we && addr == aslbu_pkg::A_ERRST |=> !ack ##1 ack)
        else $error("no wait on error read");
    AST_ACK_ONE: assert property ($rose(req) && (we || addr != aslbu_pkg::A_ERRST) |=> ack)
        else $error("late ack");
    AST_PS_OFF: assert property (wr_take && addr == aslbu_pkg::A_CKSEL |-> !mode_copy[7])
        else $error("prescale with power");
    AST_PS_OSC: assert property (wr_take && addr == aslbu_pkg::A_CKSEL |-> wdata[3:0] != aslbu_pkg::PS_OSC)
        else $error("oscillator as base");
    AST_BAUD_OFF: assert property (wr_take && addr == aslbu_pkg::A_BAUD |-> mode_copy[6:5] == 2'b00)
        else $error("divisor with enable");
    AST_BTX_ARM: assert property (wr_take && addr == aslbu_pkg::A_LCTL && wdata[5] |-> mode_copy[7:6] == 2'b11)
        else $error("break send unarmed");
    AST_BRX_ARM: assert property (wr_take && addr == aslbu_pkg::A_LCTL && wdata[6] |-> mode_copy[7] && mode_copy[5])
        else $error("break receive unarmed");
    AST_PWR_FIRST: assert property (wr_take && addr == aslbu_pkg::A_MODE && wdata[6:5] != 2'b00 |-> mode_copy[7])
        else $error("enable set before power");
    AST_TXD_PULSE: assert property (tx_done |=> !tx_done)
        else $error("long send done");
    cover property (brk_done);
    cover property (brk_err);
    cover property (tx_done);
endmodule

// >>> test_async_serial_lin_break_unit.sv
// Purpose: bench for controller and unit joined over the link
// Assumes: divisor 1 and prescale 0 give a bit time of two cycles
// Notes: the bench drives rxd_pin to make breaks of chosen length
`timescale 1ns/1ps
module test_async_serial_lin_break_unit;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, hs_clk_stopped = 1'b0, rxd_pin = 1'b1;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic pready, pslverr, irq, txd_pin, e;
    int mismatches = 0, check_count = 0, cyc = 0;
    always #25 core_clk = ~core_clk;
    aslbu_link_if aslbu_link_if_inst (.core_clk(core_clk), .sys_rst(sys_rst));
    aslbu_ctl aslbu_ctl_inst (.core_clk(core_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq), .hs_clk_stopped(hs_clk_stopped), .link(aslbu_link_if_inst));
    aslbu_serial_dev aslbu_serial_dev_inst (.link(aslbu_link_if_inst), .rxd_pin(rxd_pin), .txd_pin(txd_pin));
    aslbu_link_props aslbu_link_props_inst (.core_clk(core_clk), .sys_rst(sys_rst),
        .req(aslbu_link_if_inst.req), .we(aslbu_link_if_inst.we), .addr(aslbu_link_if_inst.addr),
        .wdata(aslbu_link_if_inst.wdata), .rdata(aslbu_link_if_inst.rdata), .ack(aslbu_link_if_inst.ack),
        .tx_done(aslbu_link_if_inst.tx_done), .brk_done(aslbu_link_if_inst.brk_done),
        .brk_err(aslbu_link_if_inst.brk_err));
    // compare and count
    task automatic chk(input logic [31:0] s, input logic [31:0] x);
        check_count++;
        if (s !== x) begin
            mismatches++;
            $display("unexpected at %0t: saw %h want %h", $time, s, x);
        end
    endtask
    // one apb transfer, held until pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // run one command to idle, check refusal; a hang ends at the guard
    task automatic tryc(input logic [3:0] c, input logic [7:0] arg, input logic refused);
        apb(1'b1, aslbu_pkg::R_IRQ_CLR, 32'h1f);
        apb(1'b1, aslbu_pkg::R_CMD, {16'h0, arg, 4'h0, c});
        do apb(1'b0, aslbu_pkg::R_STAT, 32'h0); while (q[0] !== 1'b0);
        apb(1'b0, aslbu_pkg::R_IRQ_ST, 32'h0);
        chk(32'(q[aslbu_pkg::I_REF]), 32'(refused));
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // hang guard
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            mismatches++;
            tally_and_finish;
        end
    end
    initial begin
        repeat (8) @(posedge core_clk);
        sys_rst <= 1'b0;
        chk(32'(txd_pin), 32'h1);
        apb(1'b0, aslbu_pkg::R_STAT, 32'h0);
        chk(q, 32'h0);
        apb(1'b0, 8'h14, 32'h0);
        chk({q[30:0], e}, 32'h1);
        tryc(aslbu_pkg::C_BRKTX, 8'h00, 1'b1);
        chk(32'(irq), 32'h0);
        tryc(aslbu_pkg::C_SETPS, 8'h0f, 1'b1);
        tryc(aslbu_pkg::C_SETBAUD, 8'h01, 1'b0);
        tryc(aslbu_pkg::C_SETPS, 8'h00, 1'b0);
        tryc(aslbu_pkg::C_START, 8'h60, 1'b0);
        tryc(aslbu_pkg::C_SETPS, 8'h00, 1'b1);
        tryc(aslbu_pkg::C_SETBAUD, 8'h01, 1'b1);
        tryc(aslbu_pkg::C_BRKTX, 8'h00, 1'b0);
        repeat (40) @(posedge core_clk);
        apb(1'b1, aslbu_pkg::R_IRQ_EN, 32'h1 << aslbu_pkg::I_TXC);
        tryc(aslbu_pkg::C_SEND, 8'h55, 1'b0);
        tryc(aslbu_pkg::C_SEND, 8'ha3, 1'b0);
        repeat (60) @(posedge core_clk);
        chk(32'(irq), 32'h1);
        tryc(aslbu_pkg::C_TXINIT, 8'h00, 1'b0);
        repeat (2) @(posedge core_clk);
        chk(32'(irq), 32'h0);
        tryc(aslbu_pkg::C_BRKTX, 8'h00, 1'b1);
        tryc(aslbu_pkg::C_BRKRX, 8'h00, 1'b0);
        rxd_pin <= 1'b0;
        repeat (40) @(posedge core_clk);
        rxd_pin <= 1'b1;
        repeat (10) @(posedge core_clk);
        apb(1'b0, aslbu_pkg::R_IRQ_ST, 32'h0);
        chk(32'(q[aslbu_pkg::I_BRK]), 32'h1);
        tryc(aslbu_pkg::C_BRKRX, 8'h00, 1'b0);
        rxd_pin <= 1'b0;
        repeat (6) @(posedge core_clk);
        rxd_pin <= 1'b1;
        repeat (30) @(posedge core_clk);
        apb(1'b0, aslbu_pkg::R_IRQ_ST, 32'h0);
        chk(32'(q[aslbu_pkg::I_BERR]), 32'h1);
        hs_clk_stopped <= 1'b1;
        tryc(aslbu_pkg::C_RDERR, 8'h00, 1'b1);
        hs_clk_stopped <= 1'b0;
        tryc(aslbu_pkg::C_RDERR, 8'h00, 1'b0);
        tryc(aslbu_pkg::C_STOP, 8'h00, 1'b0);
        apb(1'b0, aslbu_pkg::R_STAT, 32'h0);
        chk(32'(q[23:8]), 32'h100);
        tally_and_finish;
    end
endmodule
